// file: logic/vdpo_pkg.sv
// constants shared by the variable duty pulse output block
package vdpo_pkg;
  // clock rate and frequency scaling
  localparam longint CLK_HZ = 250_000_000;
  localparam longint FINE_STEPS_PER_HZ = 10; // fine mode counts tenths of a hertz
  localparam logic [31:0] FINE_MOD = 32'(CLK_HZ * FINE_STEPS_PER_HZ);
  localparam logic [31:0] COARSE_MOD = 32'(CLK_HZ);
  // duty ratio in tenths of a percent
  localparam logic [9:0] DUTY_FULL = 10'h3E8; // 100.0 percent
  localparam logic [31:0] FINE_THR_STEP = 32'(CLK_HZ * FINE_STEPS_PER_HZ / 1000);
  localparam logic [31:0] COARSE_THR_STEP = 32'(CLK_HZ / 1000);
  // frequency limits
  localparam logic [15:0] FREQ_MIN = 16'h0001;
  localparam logic [15:0] COARSE_FREQ_MAX = 16'h8020; // 32800 Hz
  // register byte offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] ERR_OFS = 8'h04;
  localparam logic [7:0] FUNC_OFS = 8'h08;
  localparam logic [7:0] NORMAL_OFS = 8'h0C;
  localparam logic [7:0] FREQ0_OFS = 8'h10; // freq of output n at FREQ0_OFS + n * CHAN_STRIDE
  localparam logic [7:0] DUTY0_OFS = 8'h14;
  localparam logic [7:0] CHAN_STRIDE = 8'h08;
  localparam logic [7:0] FLAGS_LO_OFS = 8'h40;
  localparam logic [7:0] FLAGS_HI_OFS = 8'h44;
  // field positions
  localparam int CMD_START_POS = 0;
  localparam int CMD_STOP_POS = 8;
  localparam int FREQ_COARSE_POS = 16;
  localparam int FLAG_EVEN_POS = 0;
  localparam int FLAG_ODD_POS = 8;
  // reset values
  localparam logic [31:0] FREQ_RST = 32'h0000_0000;
  localparam logic [31:0] DUTY_RST = 32'h0000_0000;
  localparam logic [7:0] FUNC_RST = 8'h00;
  // terminal functions, two bits per terminal
  typedef enum logic [1:0] {
    VDPO_FN_NORMAL = 2'h0,
    VDPO_FN_DUTY = 2'h1,
    VDPO_FN_ERRRST = 2'h2,
    VDPO_FN_NONE = 2'h3
  } vdpo_fn_e;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // high-time threshold on the phase accumulator
  function automatic logic [31:0] duty_threshold(input logic [9:0] duty, input logic coarse);
    logic [31:0] step;
    step = coarse ? COARSE_THR_STEP : FINE_THR_STEP;
    return 32'(duty * step);
  endfunction
endpackage

// file: logic/vdpo_chan_if.sv
// link between the register block and one pulse channel
`timescale 1ns/10ps
`default_nettype none
interface vdpo_chan_if;
  logic start; // one-cycle start command
  logic stop; // one-cycle stop command
  logic coarse; // 1 Hz steps when high, 0.1 Hz when low
  logic [15:0] freq; // frequency setting
  logic [9:0] duty; // duty setting, tenths of a percent
  logic active; // pulses in progress
  logic refused; // start rejected for a bad frequency
  logic wave; // pulse level
  modport ctrl (output start, stop, coarse, freq, duty, input active, refused, wave);
  modport chan (input start, stop, coarse, freq, duty, output active, refused, wave);
endinterface
`default_nettype wire

// file: logic/vdpo_channel.sv
// one continuous variable duty pulse channel
`timescale 1ns/10ps
`default_nettype none
module vdpo_channel (
  input wire logic aclk,
  input wire logic aresetn,
  vdpo_chan_if.chan link
);
  typedef enum logic [1:0] {
    VDPO_IDLE = 2'b01,
    VDPO_RUN = 2'b10
  } vdpo_state_e;

  vdpo_state_e state, next_state; // run state
  logic [31:0] acc, next_acc; // phase accumulator, wraps at the modulus
  logic [15:0] freq, next_freq; // frequency taken at start
  logic coarse, next_coarse; // resolution taken at start
  logic [9:0] duty_cur, next_duty_cur; // duty in force this cycle
  logic wave, next_wave; // registered pulse level
  logic refused, next_refused; // start rejected pulse
  logic [31:0] modulus; // accumulator wrap point
  logic [32:0] sum; // accumulator plus step
  logic wrap; // cycle boundary this clock
  logic start_ok; // frequency within range
  logic [9:0] duty_clip; // requested duty clipped to full scale

  assign modulus = coarse ? vdpo_pkg::COARSE_MOD : vdpo_pkg::FINE_MOD;
  assign sum = {1'b0, acc} + {17'h0_0000, freq};
  assign wrap = (state == VDPO_RUN) && (sum >= {1'b0, modulus});
  assign duty_clip = (link.duty > vdpo_pkg::DUTY_FULL) ? vdpo_pkg::DUTY_FULL : link.duty;
  // fine range runs from FREQ_MIN to the 16-bit top; coarse stops at its maximum
  assign start_ok = (link.freq >= vdpo_pkg::FREQ_MIN)
    && (!link.coarse || link.freq <= vdpo_pkg::COARSE_FREQ_MAX);

  // next state: start, stop, free running accumulation
  always_comb begin
    next_state = state;
    next_acc = acc;
    next_freq = freq;
    next_coarse = coarse;
    next_duty_cur = duty_cur;
    next_refused = 1'b0;
    if (link.stop) begin
      next_state = VDPO_IDLE;
      next_acc = 32'h0000_0000;
    end else if (link.start && start_ok) begin
      next_state = VDPO_RUN;
      next_acc = 32'h0000_0000;
      next_freq = link.freq;
      next_coarse = link.coarse;
      next_duty_cur = duty_clip;
    end else if (link.start) begin
      next_refused = 1'b1;
    end else begin
      case (state)
        VDPO_RUN: begin
          // no pulse count: cycles repeat until stopped
          if (wrap) begin
            next_acc = 32'(sum - {1'b0, modulus});
            // new duty waits for the cycle edge so no runt pulse appears
            next_duty_cur = duty_clip;
          end else begin
            next_acc = sum[31:0];
          end
        end
        VDPO_IDLE: next_acc = 32'h0000_0000;
        default: next_state = VDPO_IDLE;
      endcase
    end
    // high while the phase is under the threshold; 0 never, full always
    next_wave = (next_state == VDPO_RUN)
      && (next_acc < vdpo_pkg::duty_threshold(next_duty_cur, next_coarse));
  end

  // registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= VDPO_IDLE;
      acc <= 32'h0000_0000;
      freq <= 16'h0000;
      coarse <= 1'b0;
      duty_cur <= 10'h000;
      wave <= 1'b0;
      refused <= 1'b0;
    end else begin
      state <= next_state;
      acc <= next_acc;
      freq <= next_freq;
      coarse <= next_coarse;
      duty_cur <= next_duty_cur;
      wave <= next_wave;
      refused <= next_refused;
    end
  end

  assign link.active = (state == VDPO_RUN);
  assign link.wave = wave;
  assign link.refused = refused;

  stop_halts_a: assert property (@(posedge aclk) disable iff (!aresetn)
    link.stop |=> !link.active && !link.wave) else $error("stop did not halt output");
  start_runs_a: assert property (@(posedge aclk) disable iff (!aresetn)
    link.start && !link.stop && start_ok |=> link.active) else $error("valid start ignored");
  zero_duty_a: assert property (@(posedge aclk) disable iff (!aresetn)
    link.active && duty_cur == 10'h000 |-> !link.wave) else $error("zero duty drove high");
  full_duty_a: assert property (@(posedge aclk) disable iff (!aresetn)
    link.active && duty_cur == vdpo_pkg::DUTY_FULL |-> link.wave) else $error("full duty went low");
  duty_at_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(duty_cur) |-> $past(wrap || link.start)) else $error("duty changed mid cycle");
  keeps_running_a: assert property (@(posedge aclk) disable iff (!aresetn)
    link.active && !link.stop |=> link.active) else $error("output stopped by itself");
  bad_freq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    link.start && !link.stop && !start_ok && !link.active |=> !link.active ##0 refused)
    else $error("bad frequency accepted");
  phase_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
    link.active |-> acc < modulus) else $error("phase beyond modulus");
endmodule
`default_nettype wire

// file: logic/vdpo_top.sv
// four variable duty pulse outputs behind an axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - high/low time per cycle follows duty
// - start command begins pulses on output
// - duty changeable while running, no stop
// - duty 0.0 to 100.0 in 0.1 steps
// - fine frequency 0.1 to 6553.5 Hz
// - coarse frequency 1 to 32800 Hz
// - outputs drive four dedicated terminals
// - stop command halts the running output
// - terminal serves one function at a time
// - read-only in-progress flag per output
// - flags clear on power-up, run change
// - continuous mode only, no pulse count
module vdpo_top #(
  parameter int NUM_OUT = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // controller state and shared terminal sources
  input wire logic ctrl_run,
  input wire logic [3:0] err_reset_req,
  // terminals
  output logic duty_terminal_a0,
  output logic duty_terminal_a1,
  output logic duty_terminal_b0,
  output logic duty_terminal_b1
);
  // register map and terminal list are fixed at four outputs
  if (NUM_OUT != 4) begin : g_bad_num_out
    $error("vdpo_top serves exactly four outputs");
  end

  // byte-lane merge used by the frequency and duty registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
      input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[8*b +: 8] = wd[8*b +: 8];
    end
    return res;
  endfunction

  vdpo_chan_if ch [NUM_OUT] (); // one link per output

  // write channel state
  logic aw_held, next_aw_held; // address taken, waiting for data
  logic w_held, next_w_held; // data taken, waiting for address
  logic [7:0] waddr, next_waddr; // held write address
  logic [31:0] wdata, next_wdata; // held write data
  logic [3:0] wstrb, next_wstrb; // held byte enables
  logic bvalid, next_bvalid; // write answer pending
  logic [1:0] bresp, next_bresp; // write answer code
  // read channel state
  logic rvalid, next_rvalid; // read answer pending
  logic [31:0] rdata, next_rdata; // read answer data
  logic [1:0] rresp, next_rresp; // read answer code
  // software-visible state
  logic [31:0] freq_reg [NUM_OUT]; // frequency and resolution per output
  logic [31:0] next_freq_reg [NUM_OUT];
  logic [31:0] duty_reg [NUM_OUT]; // duty per output
  logic [31:0] next_duty_reg [NUM_OUT];
  logic [7:0] func, next_func; // terminal function, two bits each
  logic [3:0] normal, next_normal; // normal output levels
  logic [3:0] err, next_err; // refused start, sticky, write one to clear
  logic [3:0] start_cmd, next_start_cmd; // start pulses to the channels
  logic [3:0] stop_cmd, next_stop_cmd; // stop pulses to the channels
  logic run_seen; // last sampled controller state
  logic [3:0] term, next_term; // registered terminal levels
  // helpers
  logic do_write; // write performed this cycle
  logic [7:0] wa; // effective write address
  logic [31:0] wd; // effective write data
  logic [3:0] ws; // effective byte enables
  logic run_edge; // controller started or stopped
  logic [3:0] active; // in-progress flags
  logic [3:0] wave; // channel pulse levels
  logic [3:0] chan_refused; // channel rejected a frequency
  logic [3:0] is_duty; // terminal assigned to pulse output

  assign run_edge = (ctrl_run != run_seen);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      assign is_duty[gi] = (func[2*gi +: 2] == vdpo_pkg::VDPO_FN_DUTY);
      assign ch[gi].start = start_cmd[gi];
      assign ch[gi].stop = stop_cmd[gi];
      assign ch[gi].coarse = freq_reg[gi][vdpo_pkg::FREQ_COARSE_POS];
      assign ch[gi].freq = freq_reg[gi][15:0];
      assign ch[gi].duty = duty_reg[gi][9:0];
      assign active[gi] = ch[gi].active;
      assign wave[gi] = ch[gi].wave;
      assign chan_refused[gi] = ch[gi].refused;
      vdpo_channel u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .link(ch[gi])
      );
    end
  endgenerate

  // effective write: held halves or those arriving now, either order
  always_comb begin
    wa = aw_held ? waddr : s_axi_awaddr;
    wd = w_held ? wdata : s_axi_wdata;
    ws = w_held ? wstrb : s_axi_wstrb;
    do_write = !bvalid && (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid);
  end

  assign s_axi_awready = !bvalid && !aw_held;
  assign s_axi_wready = !bvalid && !w_held;
  assign s_axi_arready = !rvalid;

  // next values of the bus slave and the register file
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_freq_reg = freq_reg;
    next_duty_reg = duty_reg;
    next_func = func;
    next_normal = normal;
    next_start_cmd = 4'h0;
    next_stop_cmd = 4'h0;
    next_err = err;
    // hold halves that arrive alone
    if (s_axi_awvalid && s_axi_awready && !do_write) begin
      next_aw_held = 1'b1;
      next_waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready && !do_write) begin
      next_w_held = 1'b1;
      next_wdata = s_axi_wdata;
      next_wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = vdpo_pkg::RESP_OKAY;
      if (wa[7:2] == vdpo_pkg::CMD_OFS[7:2]) begin
        // commands only honoured on byte lanes that are enabled
        if (ws[0]) next_start_cmd = wd[vdpo_pkg::CMD_START_POS +: 4];
        if (ws[1]) next_stop_cmd = wd[vdpo_pkg::CMD_STOP_POS +: 4];
      end else if (wa[7:2] == vdpo_pkg::ERR_OFS[7:2]) begin
        if (ws[0]) next_err = err & ~wd[3:0];
      end else if (wa[7:2] == vdpo_pkg::FUNC_OFS[7:2]) begin
        if (ws[0]) next_func = wd[7:0];
      end else if (wa[7:2] == vdpo_pkg::NORMAL_OFS[7:2]) begin
        if (ws[0]) next_normal = wd[3:0];
      end else if (wa[7:6] == 2'h0 && wa[1:0] == 2'h0 && (wa[5:4] == 2'h1 || wa[5:4] == 2'h2)) begin
        // per-output frequency and duty words, 0x10 to 0x2C
        if (wa[2]) next_duty_reg[2'(wa[5:3] - 3'h2)] = merge(duty_reg[2'(wa[5:3] - 3'h2)], wd, ws) & 32'h0000_03FF;
        else next_freq_reg[2'(wa[5:3] - 3'h2)] = merge(freq_reg[2'(wa[5:3] - 3'h2)], wd, ws) & 32'h0001_FFFF;
      end else begin
        next_bresp = vdpo_pkg::RESP_SLVERR; // unmapped or read-only
      end
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // a start on a terminal held by another function is refused
    for (int i = 0; i < NUM_OUT; i++) begin
      if (next_start_cmd[i] && (!is_duty[i] || !ctrl_run)) begin
        next_start_cmd[i] = 1'b0;
        next_err[i] = 1'b1;
      end
      // taking the terminal away from pulse output stops the channel
      if (active[i] && !is_duty[i]) next_stop_cmd[i] = 1'b1;
      if (chan_refused[i]) next_err[i] = 1'b1; // set wins over clear
    end
    // controller start or stop ends every output and clears the flags
    if (run_edge) begin
      next_stop_cmd = 4'hF;
      next_start_cmd = 4'h0;
    end
    // read channel
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = vdpo_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr[7:2] == vdpo_pkg::CMD_OFS[7:2]) begin
        next_rdata = 32'h0000_0000; // commands read as zero
      end else if (s_axi_araddr[7:2] == vdpo_pkg::ERR_OFS[7:2]) begin
        next_rdata = {28'h000_0000, err};
      end else if (s_axi_araddr[7:2] == vdpo_pkg::FUNC_OFS[7:2]) begin
        next_rdata = {24'h00_0000, func};
      end else if (s_axi_araddr[7:2] == vdpo_pkg::NORMAL_OFS[7:2]) begin
        next_rdata = {28'h000_0000, normal};
      end else if (s_axi_araddr[7:2] == vdpo_pkg::FLAGS_LO_OFS[7:2]) begin
        next_rdata[vdpo_pkg::FLAG_EVEN_POS] = active[0];
        next_rdata[vdpo_pkg::FLAG_ODD_POS] = active[1];
      end else if (s_axi_araddr[7:2] == vdpo_pkg::FLAGS_HI_OFS[7:2]) begin
        next_rdata[vdpo_pkg::FLAG_EVEN_POS] = active[2];
        next_rdata[vdpo_pkg::FLAG_ODD_POS] = active[3];
      end else if (s_axi_araddr[7:6] == 2'h0 && (s_axi_araddr[5:4] == 2'h1 || s_axi_araddr[5:4] == 2'h2)) begin
        // only 0x10 to 0x2C; 0x30 to 0x3C is unmapped, not an alias
        next_rdata = s_axi_araddr[2] ? duty_reg[2'(s_axi_araddr[5:3] - 3'h2)]
          : freq_reg[2'(s_axi_araddr[5:3] - 3'h2)];
      end else begin
        next_rresp = vdpo_pkg::RESP_SLVERR;
      end
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // terminal multiplexer: one function per terminal
  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      case (vdpo_pkg::vdpo_fn_e'(func[2*i +: 2]))
        vdpo_pkg::VDPO_FN_DUTY: next_term[i] = wave[i];
        vdpo_pkg::VDPO_FN_NORMAL: next_term[i] = normal[i];
        vdpo_pkg::VDPO_FN_ERRRST: next_term[i] = err_reset_req[i];
        default: next_term[i] = 1'b0;
      endcase
    end
  end

  // registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      waddr <= 8'h00;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= vdpo_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= vdpo_pkg::RESP_OKAY;
      for (int i = 0; i < NUM_OUT; i++) begin
        freq_reg[i] <= vdpo_pkg::FREQ_RST;
        duty_reg[i] <= vdpo_pkg::DUTY_RST;
      end
      func <= vdpo_pkg::FUNC_RST;
      normal <= 4'h0;
      err <= 4'h0;
      start_cmd <= 4'h0;
      stop_cmd <= 4'h0;
      run_seen <= 1'b0;
      term <= 4'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      freq_reg <= next_freq_reg;
      duty_reg <= next_duty_reg;
      func <= next_func;
      normal <= next_normal;
      err <= next_err;
      start_cmd <= next_start_cmd;
      stop_cmd <= next_stop_cmd;
      run_seen <= ctrl_run;
      term <= next_term;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign duty_terminal_a0 = term[0];
  assign duty_terminal_a1 = term[1];
  assign duty_terminal_b0 = term[2];
  assign duty_terminal_b1 = term[3];

  run_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run_edge |-> ##2 active == 4'h0) else $error("flags not cleared on run change");
  one_function_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !is_duty[0] |-> ##2 !active[0]) else $error("pulses on a terminal not assigned");
  term_follows_a: assert property (@(posedge aclk) disable iff (!aresetn)
    is_duty[0] |=> duty_terminal_a0 == $past(wave[0])) else $error("terminal not fed by pulse");
  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer dropped");
endmodule
`default_nettype wire

// file: verification/vdpo_load.sv
// behavioural load that measures the pulse train on one terminal
`timescale 1ns/10ps
`default_nettype none
module vdpo_load (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic terminal, // high energises the load
  output logic [31:0] high_time, // high cycles of the last full cycle
  output logic [31:0] period, // cycles between the last two rising edges
  output logic [31:0] steady // cycles since the level last changed
);
  logic prev; // level one cycle ago
  logic [31:0] cnt; // cycles of the open cycle
  logic [31:0] hcnt; // high cycles of the open cycle
  // a lamp or heater only sees the level, so nothing is driven back
  always @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 1'b0;
      cnt <= 32'h0;
      hcnt <= 32'h0;
      high_time <= 32'h0;
      period <= 32'h0;
      steady <= 32'h0;
    end else begin
      prev <= terminal;
      steady <= (terminal != prev) ? 32'h0 : steady + 32'h1;
      // a rising edge closes one cycle and opens the next
      if (terminal && !prev) begin
        period <= cnt;
        high_time <= hcnt;
        cnt <= 32'h1;
        hcnt <= 32'h1;
      end else begin
        cnt <= cnt + 32'h1;
        hcnt <= hcnt + {31'h0, terminal};
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/tb.sv
// self-checking bench for the variable duty pulse outputs
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic aclk = 1'b0; // 250 MHz
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [3:0] wstrb = 4'hF;
  logic [3:0] err_req = 4'hF; // only terminal 3 listens to it
  logic [3:0] term;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic ctrl_run = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] hi_t [4];
  logic [31:0] per [4];
  logic [31:0] stdy [4];
  logic [34:0] rq [$]; // expected reads: check-data bit, resp, data
  logic [1:0] bq [$]; // expected write responses
  logic [34:0] e;
  logic [9:0] d1; // random duty for output 1
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 32'hf727;
  localparam logic [31:0] FQ = 32'h0001_61A8; // coarse 25000 Hz, 10000 cycles

  always #2 aclk = ~aclk;

  vdpo_top vdpo_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ctrl_run(ctrl_run), .err_reset_req(err_req),
    .duty_terminal_a0(term[0]), .duty_terminal_a1(term[1]),
    .duty_terminal_b0(term[2]), .duty_terminal_b1(term[3]));

  // one load per terminal, index equals output number
  for (genvar i = 0; i < 4; i++) begin : g_load
    vdpo_load vdpo_load_inst (.aclk(aclk), .aresetn(aresetn), .terminal(term[i]),
      .high_time(hi_t[i]), .period(per[i]), .steady(stdy[i]));
  end

  task automatic fail(input logic [34:0] g, input logic [34:0] x);
    errors++;
    $display("ERROR t=%0t got %h exp %h", $time, g, x);
  endtask

  // bus results: exact match
  task automatic cmp_bus(input logic [34:0] g, input logic [34:0] x);
    n_tests++;
    if (g !== x) fail(g, x);
  endtask

  // load measurements: match within a tolerance for phase rounding
  task automatic cmp_load(input logic [31:0] g, input logic [31:0] x, input logic [31:0] tol);
    n_tests++;
    if ((g + tol >= x && g <= x + tol) !== 1'b1) fail({3'h0, g}, {3'h0, x});
  endtask

  function automatic logic [34:0] okd(input logic [31:0] d);
    return {1'b1, vdpo_pkg::RESP_OKAY, d};
  endfunction

  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta | (awvalid && awready);
      tw = tw | (wvalid && wready);
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [34:0] x);
    rq.push_back(x);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // watcher: sampled mid-cycle, so each handshake is seen exactly once
  always @(negedge aclk) begin
    if (rvalid && rready) begin
      e = rq.pop_front();
      cmp_bus({e[34], rresp, e[34] ? rdata : 32'h0}, e);
    end
    if (bvalid && bready) cmp_bus({33'h0, bresp}, {33'h0, bq.pop_front()});
  end

  task automatic report_and_stop;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well above the roughly 45000 cycles the sequence needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      report_and_stop;
    end
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(vdpo_pkg::FLAGS_LO_OFS, okd(32'h0));
    rd(vdpo_pkg::FLAGS_HI_OFS, okd(32'h0));
    d1 = 10'((32'($random(seed)) & 32'h3FF) % 999 + 1);
    // terminals 0..2 pulse, terminal 3 error-counter reset only
    wr(vdpo_pkg::FUNC_OFS, 32'h0000_0095, 2'h0);
    wr(8'h10, FQ, 2'h0);
    wr(8'h14, 32'h0000_0190, 2'h0);
    wr(8'h18, FQ, 2'h0);
    wr(8'h1C, {22'h0, d1}, 2'h0);
    wr(8'h20, 32'h0000_FFFF, 2'h0);
    // half duty on the fine output so that its period shows on the load
    wr(8'h24, 32'h0000_01F4, 2'h0);
    wr(8'h28, FQ, 2'h0);
    wr(vdpo_pkg::CMD_OFS, 32'h0000_000F, 2'h0);
    rd(vdpo_pkg::ERR_OFS, okd(32'h8));
    rd(vdpo_pkg::FLAGS_LO_OFS, okd(32'h101));
    rd(vdpo_pkg::FLAGS_HI_OFS, okd(32'h1));
    repeat (25000) @(posedge aclk);
    cmp_load(per[0], 32'd10000, 32'd2);
    cmp_load(hi_t[0], 32'd4000, 32'd2);
    cmp_load(hi_t[1], 32'(d1) * 32'd10, 32'd2);
    cmp_load({31'h0, term[3]}, 32'h1, 32'h0);
    // duty changes while running, no stop in between
    wr(8'h14, 32'h0000_03E8, 2'h0);
    wr(8'h1C, 32'h0000_0000, 2'h0);
    repeat (20000) @(posedge aclk);
    cmp_load({31'h0, term[0]}, 32'h1, 32'h0);
    cmp_load(stdy[0], 32'd15000, 32'd6000);
    cmp_load({31'h0, term[1]}, 32'h0, 32'h0);
    // last fall lies up to one period before or after the write, so 10000 to 30000
    cmp_load(stdy[1], 32'd20000, 32'd10000);
    // 6553.5 Hz fine: 2.5e9 / 65535 cycles, first cycle counted from start
    cmp_load(per[2], 32'd38148, 32'd2);
    rd(vdpo_pkg::FLAGS_LO_OFS, okd(32'h101));
    wr(vdpo_pkg::CMD_OFS, 32'h0000_0100, 2'h0);
    rd(vdpo_pkg::FLAGS_LO_OFS, okd(32'h100));
    cmp_load({31'h0, term[0]}, 32'h0, 32'h0);
    // coarse setting one step above its top must be refused by the channel
    wr(8'h10, 32'h0001_8021, 2'h0);
    wr(vdpo_pkg::CMD_OFS, 32'h0000_0001, 2'h0);
    rd(vdpo_pkg::ERR_OFS, okd(32'h9));
    ctrl_run <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(vdpo_pkg::FLAGS_LO_OFS, okd(32'h0));
    rd(vdpo_pkg::FLAGS_HI_OFS, okd(32'h0));
    cmp_load({29'h0, term[2:0]}, 32'h0, 32'h0);
    rd(8'h3C, {1'b0, vdpo_pkg::RESP_SLVERR, 32'h0});
    wr(vdpo_pkg::FLAGS_LO_OFS, 32'h1, vdpo_pkg::RESP_SLVERR);
    rd(vdpo_pkg::FLAGS_LO_OFS, okd(32'h0));
    repeat (5) @(posedge aclk);
    report_and_stop;
  end
endmodule
`default_nettype wire
